// *** hdl/hwps_pkg.sv ***
// Package: constants for the hardware position switch
package hwps_pkg;
  // ==========================================================================
  // Register map (byte addresses)
  // ==========================================================================
  localparam logic [7:0] HWPS_CTRL_ADDR   = 8'h00;
  localparam logic [7:0] HWPS_START_ADDR  = 8'h04;
  localparam logic [7:0] HWPS_END_ADDR    = 8'h08;
  localparam logic [7:0] HWPS_AXTYPE_ADDR = 8'h0C;
  localparam logic [7:0] HWPS_STATUS_ADDR = 8'h10;
  localparam logic [7:0] HWPS_TWADDR_ADDR = 8'h14;
  localparam logic [7:0] HWPS_TWDATA_ADDR = 8'h18;
  localparam logic [7:0] HWPS_POS_ADDR    = 8'h1C;
  // ==========================================================================
  // Control fields
  // ==========================================================================
  localparam int HWPS_MODE_LSB   = 0;
  localparam int HWPS_DIR_BIT    = 4;
  localparam int HWPS_OPST_BIT   = 5;
  localparam logic [1:0] HWPS_MODE_DISABLE = 2'h0;
  localparam logic [1:0] HWPS_MODE_LOAD    = 2'h1;
  localparam logic [1:0] HWPS_MODE_CLEAR   = 2'h2;
  // ==========================================================================
  // Axis types, sizes, bus responses and sequencer states
  // ==========================================================================
  localparam logic [7:0] HWPS_AXTYPE_A = 8'h2B;
  localparam logic [7:0] HWPS_AXTYPE_B = 8'h2C;
  localparam logic [7:0] HWPS_AXTYPE_C = 8'h2D;
  localparam int HWPS_TBL_AW  = 6;
  localparam int HWPS_TBL_N   = 64;
  localparam int HWPS_Q_AW    = 6;
  localparam int HWPS_Q_N     = 64;
  localparam int HWPS_OUT_NUM = 8;
  localparam logic [1:0] HWPS_RESP_OKAY   = 2'h0;
  localparam logic [1:0] HWPS_RESP_SLVERR = 2'h2;
  typedef enum logic [1:0] {HWPS_IDLE, HWPS_LOAD, HWPS_RUN} hwps_state_t;
endpackage

// *** hdl/hwps_queue.sv ***
// Position queue holding preset compare positions
`timescale 1ns/10ps
module hwps_queue
  import hwps_pkg::*;
(
  input  wire logic               clk,
  input  wire logic               reset,
  input  wire logic               clear,
  input  wire logic               push,
  input  wire logic signed [31:0] pushData,
  input  wire logic               pop,
  output logic signed [31:0]      headData,
  output logic                    empty,
  output logic                    full,
  output logic [HWPS_Q_AW:0]      count
);
  // ==========================================================================
  // Storage
  // ==========================================================================
  logic signed [31:0] mem [HWPS_Q_N];
  logic [HWPS_Q_AW-1:0] wrPtr_reg;
  logic [HWPS_Q_AW-1:0] rdPtr_reg;
  logic [HWPS_Q_AW:0]   count_reg;
  logic                 doPush;
  logic                 doPop;

  assign doPush   = push && !full && !clear;
  assign doPop    = pop && !empty && !clear;
  assign empty    = (count_reg == '0);
  assign full     = (count_reg == (HWPS_Q_AW+1)'(HWPS_Q_N));
  assign count    = count_reg;
  assign headData = mem[rdPtr_reg];

  always_ff @(posedge clk)
  begin
    if (doPush)
    begin
      mem[wrPtr_reg] <= pushData;
    end
  end

  // Clear empties the queue in one cycle
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      wrPtr_reg <= '0;
      rdPtr_reg <= '0;
      count_reg <= '0;
    end
    else if (clear)
    begin
      wrPtr_reg <= '0;
      rdPtr_reg <= '0;
      count_reg <= '0;
    end
    else
    begin
      if (doPush)
      begin
        wrPtr_reg <= wrPtr_reg + 1'b1;
      end
      if (doPop)
      begin
        rdPtr_reg <= rdPtr_reg + 1'b1;
      end
      count_reg <= count_reg + (HWPS_Q_AW+1)'(doPush) - (HWPS_Q_AW+1)'(doPop);
    end
  end
endmodule

// *** hdl/hwps_switch.sv ***
// Hardware position switch for one axis with AXI4-Lite registers
// Operation
// - When enabled, output 8 of the axis is driven once the position reaches the queue head.
// - After the first reach, the output toggles when the next queued position is reached.
// - Load-and-enable copies table entries from start through end index into the queue.
// - The switch works only for axis type codes 43, 44 and 45.
// - Mode 0 disables, mode 1 enables and loads, mode 2 clears the queue.
// - Direction 0 compares on decreasing position, 1 on increasing position.
// - The first queued position drives the output to the commanded initial state.
// - Each later queued position toggles the output, up to the last entry.
// - Disable stops the switch but leaves the queue contents alone.
// - Clear empties the queue of all loaded entries.
//
// The AXI4-Lite register port and the placing of the registers were chosen for this implementation.
`timescale 1ns/10ps
module hwps_switch
  import hwps_pkg::*;
(
  input  wire logic               clk,
  input  wire logic               reset,
  input  wire logic signed [31:0] measuredPos,
  input  wire logic [7:0]         s_axi_awaddr,
  input  wire logic               s_axi_awvalid,
  output logic                    s_axi_awready,
  input  wire logic [31:0]        s_axi_wdata,
  input  wire logic [3:0]         s_axi_wstrb,
  input  wire logic               s_axi_wvalid,
  output logic                    s_axi_wready,
  output logic [1:0]              s_axi_bresp,
  output logic                    s_axi_bvalid,
  input  wire logic               s_axi_bready,
  input  wire logic [7:0]         s_axi_araddr,
  input  wire logic               s_axi_arvalid,
  output logic                    s_axi_arready,
  output logic [31:0]             s_axi_rdata,
  output logic [1:0]              s_axi_rresp,
  output logic                    s_axi_rvalid,
  input  wire logic               s_axi_rready,
  output logic                    switchOut
);
  // ==========================================================================
  // Decode helpers
  // ==========================================================================
  function automatic logic typeOk(input logic [7:0] code);
    typeOk = (code == HWPS_AXTYPE_A) || (code == HWPS_AXTYPE_B) || (code == HWPS_AXTYPE_C);
  endfunction

  function automatic logic [31:0] strbMerge(input logic [31:0] old,
                                            input logic [31:0] nw,
                                            input logic [3:0]  strb);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++)
    begin
      if (strb[i])
      begin
        r[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    strbMerge = r;
  endfunction

  // ==========================================================================
  // Registers
  // ==========================================================================
  logic                  dir_reg;
  logic                  opState_reg;
  logic                  enable_reg;
  logic [HWPS_TBL_AW-1:0] start_reg;
  logic [HWPS_TBL_AW-1:0] end_reg;
  logic [7:0]            axisType_reg;
  logic [HWPS_TBL_AW-1:0] twAddr_reg;
  logic signed [31:0]    table_mem [HWPS_TBL_N];
  logic                  firstDone_reg;
  logic                  badType_reg;
  hwps_state_t           state_reg;
  logic [HWPS_TBL_AW-1:0] loadIdx_reg;

  logic                  awHeld_reg;
  logic                  wHeld_reg;
  logic [7:0]            awAddr_reg;
  logic [31:0]           wData_reg;
  logic [3:0]            wStrb_reg;
  logic                  wrFire;
  logic                  cmdWrite;
  logic [1:0]            cmdMode;

  logic                  qClear;
  logic                  qPush;
  logic                  qPop;
  logic signed [31:0]    qHead;
  logic                  qEmpty;
  logic                  qFull;
  logic [HWPS_Q_AW:0]    qCount;
  logic                  reached;

  // ==========================================================================
  // AXI4-Lite write channel
  // ==========================================================================
  assign wrFire   = awHeld_reg && wHeld_reg && !s_axi_bvalid;
  assign cmdWrite = wrFire && (awAddr_reg == HWPS_CTRL_ADDR) && wStrb_reg[0];
  assign cmdMode  = wData_reg[HWPS_MODE_LSB +: 2];

  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      awHeld_reg    <= 1'b0;
      wHeld_reg     <= 1'b0;
      awAddr_reg    <= '0;
      wData_reg     <= '0;
      wStrb_reg     <= '0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= HWPS_RESP_OKAY;
    end
    else
    begin
      s_axi_awready <= !awHeld_reg && !s_axi_awready && s_axi_awvalid;
      s_axi_wready  <= !wHeld_reg && !s_axi_wready && s_axi_wvalid;
      if (s_axi_awvalid && s_axi_awready)
      begin
        awHeld_reg <= 1'b1;
        awAddr_reg <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        wHeld_reg <= 1'b1;
        wData_reg <= s_axi_wdata;
        wStrb_reg <= s_axi_wstrb;
      end
      if (wrFire)
      begin
        awHeld_reg   <= 1'b0;
        wHeld_reg    <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= (awAddr_reg > HWPS_POS_ADDR || awAddr_reg[1:0] != 2'h0)
                        ? HWPS_RESP_SLVERR : HWPS_RESP_OKAY;
      end
      else if (s_axi_bvalid && s_axi_bready)
      begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // Configuration and table writes
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      start_reg    <= '0;
      end_reg      <= '0;
      axisType_reg <= '0;
      twAddr_reg   <= '0;
    end
    else if (wrFire)
    begin
      case (awAddr_reg)
        HWPS_START_ADDR:  start_reg    <= HWPS_TBL_AW'(strbMerge(32'(start_reg), wData_reg,
                                                                 wStrb_reg));
        HWPS_END_ADDR:    end_reg      <= HWPS_TBL_AW'(strbMerge(32'(end_reg), wData_reg,
                                                                 wStrb_reg));
        HWPS_AXTYPE_ADDR: axisType_reg <= 8'(strbMerge(32'(axisType_reg), wData_reg,
                                                       wStrb_reg));
        HWPS_TWADDR_ADDR: twAddr_reg   <= HWPS_TBL_AW'(strbMerge(32'(twAddr_reg), wData_reg,
                                                                 wStrb_reg));
        HWPS_TWDATA_ADDR: twAddr_reg   <= twAddr_reg + 1'b1;
        default:          twAddr_reg   <= twAddr_reg;
      endcase
    end
  end

  // Table memory, auto-increment writes
  always_ff @(posedge clk)
  begin
    if (wrFire && awAddr_reg == HWPS_TWDATA_ADDR)
    begin
      table_mem[twAddr_reg] <= strbMerge(table_mem[twAddr_reg], wData_reg, wStrb_reg);
    end
  end

  // ==========================================================================
  // Command handling and sequencing
  // ==========================================================================
  // Load only copies; the queue is not cleared first, so reruns need a clear
  assign qClear  = cmdWrite && cmdMode == HWPS_MODE_CLEAR;
  assign qPush   = state_reg == HWPS_LOAD && !qFull;
  assign reached = enable_reg && state_reg == HWPS_RUN && !qEmpty
                   && (dir_reg ? (measuredPos >= qHead) : (measuredPos <= qHead));
  assign qPop    = reached;

  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      state_reg   <= HWPS_IDLE;
      enable_reg  <= 1'b0;
      dir_reg     <= 1'b0;
      opState_reg <= 1'b0;
      loadIdx_reg <= '0;
      badType_reg <= 1'b0;
    end
    else if (cmdWrite)
    begin
      case (cmdMode)
        HWPS_MODE_DISABLE:
        begin
          enable_reg <= 1'b0;
          state_reg  <= HWPS_IDLE;
        end
        HWPS_MODE_LOAD:
        begin
          // Unsupported axis types refuse the enable
          if (typeOk(axisType_reg))
          begin
            enable_reg  <= 1'b1;
            dir_reg     <= wData_reg[HWPS_DIR_BIT];
            opState_reg <= wData_reg[HWPS_OPST_BIT];
            loadIdx_reg <= start_reg;
            state_reg   <= HWPS_LOAD;
            badType_reg <= 1'b0;
          end
          else
          begin
            badType_reg <= 1'b1;
          end
        end
        default:
        begin
          state_reg <= state_reg;
        end
      endcase
    end
    else
    begin
      case (state_reg)
        HWPS_LOAD:
        begin
          if (qFull || loadIdx_reg == end_reg)
          begin
            state_reg <= HWPS_RUN;
          end
          else
          begin
            loadIdx_reg <= loadIdx_reg + 1'b1;
          end
        end
        HWPS_RUN:  state_reg <= HWPS_RUN;
        HWPS_IDLE: state_reg <= HWPS_IDLE;
        default:   state_reg <= HWPS_IDLE;
      endcase
    end
  end

  // ==========================================================================
  // Output drive
  // ==========================================================================
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      switchOut     <= 1'b0;
      firstDone_reg <= 1'b0;
    end
    else
    begin
      // A reach in the cycle of a reload still acts on the old sequence
      firstDone_reg <= (cmdWrite && cmdMode == HWPS_MODE_LOAD && typeOk(axisType_reg))
                       ? 1'b0 : (firstDone_reg || reached);
      if (reached && !firstDone_reg)
      begin
        switchOut <= opState_reg;
      end
      else if (reached)
      begin
        switchOut <= !switchOut;
      end
    end
  end

  // ==========================================================================
  // AXI4-Lite read channel
  // ==========================================================================
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= '0;
      s_axi_rresp   <= HWPS_RESP_OKAY;
    end
    else
    begin
      s_axi_arready <= !s_axi_rvalid && !s_axi_arready && s_axi_arvalid;
      if (s_axi_arvalid && s_axi_arready)
      begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp  <= HWPS_RESP_OKAY;
        case (s_axi_araddr)
          HWPS_CTRL_ADDR:   s_axi_rdata <= {26'h0, opState_reg, dir_reg, 3'h0, enable_reg};
          HWPS_START_ADDR:  s_axi_rdata <= 32'(start_reg);
          HWPS_END_ADDR:    s_axi_rdata <= 32'(end_reg);
          HWPS_AXTYPE_ADDR: s_axi_rdata <= 32'(axisType_reg);
          HWPS_STATUS_ADDR: s_axi_rdata <= {16'h0, 1'(state_reg == HWPS_LOAD), badType_reg,
                                            switchOut, enable_reg, 5'h0, qCount};
          HWPS_TWADDR_ADDR: s_axi_rdata <= 32'(twAddr_reg);
          HWPS_TWDATA_ADDR: s_axi_rdata <= table_mem[twAddr_reg];
          HWPS_POS_ADDR:    s_axi_rdata <= qEmpty ? 32'h0 : qHead;
          default:
          begin
            s_axi_rdata <= 32'h0;
            s_axi_rresp <= HWPS_RESP_SLVERR;
          end
        endcase
      end
      else if (s_axi_rvalid && s_axi_rready)
      begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // ==========================================================================
  // Queue
  // ==========================================================================
  hwps_queue u_queue (
    .clk      (clk),
    .reset    (reset),
    .clear    (qClear),
    .push     (qPush),
    .pushData (table_mem[loadIdx_reg]),
    .pop      (qPop),
    .headData (qHead),
    .empty    (qEmpty),
    .full     (qFull),
    .count    (qCount)
  );
endmodule

// *** tb/hwps_switch_checker.sv ***
// Checker: bus and output assertions for the position switch
`timescale 1ns/10ps
module hwps_switch_checker
  import hwps_pkg::*;
(
  input wire logic               clk,
  input wire logic               reset,
  input wire logic signed [31:0] measuredPos,
  input wire logic [7:0]         s_axi_awaddr,
  input wire logic               s_axi_awvalid,
  input wire logic               s_axi_awready,
  input wire logic [31:0]        s_axi_wdata,
  input wire logic [3:0]         s_axi_wstrb,
  input wire logic               s_axi_wvalid,
  input wire logic               s_axi_wready,
  input wire logic [1:0]         s_axi_bresp,
  input wire logic               s_axi_bvalid,
  input wire logic               s_axi_bready,
  input wire logic [7:0]         s_axi_araddr,
  input wire logic               s_axi_arvalid,
  input wire logic               s_axi_arready,
  input wire logic [31:0]        s_axi_rdata,
  input wire logic [1:0]         s_axi_rresp,
  input wire logic               s_axi_rvalid,
  input wire logic               s_axi_rready,
  input wire logic               switchOut
);
  logic [7:0] wAddr_reg;
  logic [7:0] rAddr_reg;
  logic [1:0] mode_reg;
  logic       en_reg;
  logic       wOk;
  logic       rOk;
  assign wOk = (wAddr_reg <= HWPS_POS_ADDR) && (wAddr_reg[1:0] == 2'h0);
  assign rOk = (rAddr_reg <= HWPS_POS_ADDR) && (rAddr_reg[1:0] == 2'h0);
  // ==========================================
  // Bus capture
  // ==========================================
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      wAddr_reg <= 8'h00;
      rAddr_reg <= 8'h00;
      mode_reg  <= 2'h3;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
        wAddr_reg <= s_axi_awaddr;
      if (s_axi_wvalid && s_axi_wready)
        mode_reg <= s_axi_wdata[1:0];
      if (s_axi_arvalid && s_axi_arready)
        rAddr_reg <= s_axi_araddr;
    end
  end
  // One cycle late; loading time hides the lag
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
      en_reg <= 1'b0;
    else if ($rose(s_axi_bvalid) && wOk && wAddr_reg == HWPS_CTRL_ADDR)
    begin
      if (mode_reg == HWPS_MODE_LOAD)
        en_reg <= 1'b1;
      else if (mode_reg == HWPS_MODE_DISABLE)
        en_reg <= 1'b0;
    end
  end
  // ==========================================
  // Assertions
  // ==========================================
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (reset);
  sequence sWrTaken;
    s_axi_wvalid && s_axi_wready;
  endsequence
  sequence sRdTaken;
    s_axi_arvalid && s_axi_arready;
  endsequence
  a_aw_pulse: assert property (s_axi_awready |=> !s_axi_awready)
    else $error("awready longer than one cycle");
  a_wr_answer: assert property (sWrTaken |-> ##[1:3] s_axi_bvalid)
    else $error("write response missing");
  a_b_hold: assert property (s_axi_bvalid && !s_axi_bready
                             |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  a_rd_answer: assert property (sRdTaken |=> s_axi_rvalid)
    else $error("read data late");
  a_r_hold: assert property (s_axi_rvalid && !s_axi_rready
                             |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
  a_wr_resp: assert property (s_axi_bvalid
                              |-> s_axi_bresp == (wOk ? HWPS_RESP_OKAY : HWPS_RESP_SLVERR))
    else $error("bad write response");
  a_rd_err: assert property (s_axi_rvalid && !rOk
                             |-> s_axi_rresp == HWPS_RESP_SLVERR && s_axi_rdata == 32'h0)
    else $error("bad unmapped read");
  a_out_hold: assert property (!en_reg |=> $stable(switchOut))
    else $error("output moved while disabled");
endmodule
bind hwps_switch hwps_switch_checker chk (.*);

// *** tb/hwps_axis_model.sv ***
// Axis model: measured position ramping toward a target
`timescale 1ns/10ps
module hwps_axis_model
#(
  parameter int STEP = 32'hA
)
(
  input wire logic               clk,
  input wire logic               reset,
  input wire logic signed [31:0] target,
  output logic signed [31:0]     measuredPos
);
  // Bounded steps so no table position is jumped unseen
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
      measuredPos <= 32'sh0;
    else if (target > measuredPos)
      measuredPos <= (target - measuredPos > STEP) ? measuredPos + STEP : target;
    else if (target < measuredPos)
      measuredPos <= (measuredPos - target > STEP) ? measuredPos - STEP : target;
  end
endmodule

// *** tb/hwps_switch_tb.sv ***
// Testbench: position switch through its register bus and axis input
`timescale 1ns/10ps
module hwps_switch_tb
  import hwps_pkg::*;
  ;
  localparam logic [7:0] TYPE_ADDR = 8'h0C;
  logic               clk = 1'b0;
  logic               reset = 1'b1;
  logic signed [31:0] target = 32'sh0;
  logic signed [31:0] measuredPos;
  logic [7:0]         s_axi_awaddr = 8'h00;
  logic               s_axi_awvalid = 1'b0;
  logic               s_axi_awready;
  logic [31:0]        s_axi_wdata = 32'h0;
  logic [3:0]         s_axi_wstrb = 4'hF;
  logic               s_axi_wvalid = 1'b0;
  logic               s_axi_wready;
  logic [1:0]         s_axi_bresp;
  logic               s_axi_bvalid;
  logic               s_axi_bready = 1'b0;
  logic [7:0]         s_axi_araddr = 8'h00;
  logic               s_axi_arvalid = 1'b0;
  logic               s_axi_arready;
  logic [31:0]        s_axi_rdata;
  logic [1:0]         s_axi_rresp;
  logic               s_axi_rvalid;
  logic               s_axi_rready = 1'b0;
  logic               switchOut;
  int                 failures = 0;
  int                 n_compared = 0;
  always #50 clk = ~clk;
  hwps_axis_model axis (.clk(clk), .reset(reset), .target(target), .measuredPos(measuredPos));
  hwps_switch dut (.*);
  // ==========================================
  // Bus and compare tasks
  // ==========================================
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      failures++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // Ready sampled at the falling edge; flops hold it to the rising one
  task automatic axw(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    int   n;
    logic ta;
    logic tw;
    logic tb;
    n = 0;
    @(posedge clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (n < 50)
    begin
      @(negedge clk);
      ta = s_axi_awready;
      tw = s_axi_wready;
      tb = s_axi_bvalid;
      r = s_axi_bresp;
      @(posedge clk);
      n++;
      if (ta)
        s_axi_awvalid <= 1'b0;
      if (tw)
        s_axi_wvalid <= 1'b0;
      if (tb)
      begin
        s_axi_bready <= 1'b0;
        n = 99;
      end
    end
    if (n != 99)
      failures++;
  endtask
  // Rready goes up with the request and stays until rvalid is seen
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    int   n;
    logic ta;
    logic tk;
    n = 0;
    @(posedge clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    while (n < 50)
    begin
      @(negedge clk);
      ta = s_axi_arready;
      tk = s_axi_rvalid && s_axi_rready;
      d = s_axi_rdata;
      r = s_axi_rresp;
      @(posedge clk);
      n++;
      if (ta)
        s_axi_arvalid <= 1'b0;
      if (tk)
      begin
        s_axi_rready <= 1'b0;
        n = 99;
      end
    end
    if (n != 99)
      failures++;
  endtask
  task automatic fill(input logic [5:0] p, input logic [31:0] a, b, c);
    logic [1:0] r;
    axw(HWPS_TWADDR_ADDR, {26'h0, p}, r);
    axw(HWPS_TWDATA_ADDR, a, r);
    axw(HWPS_TWDATA_ADDR, b, r);
    axw(HWPS_TWDATA_ADDR, c, r);
  endtask
  task automatic cmd(input logic [7:0] ty, input logic [5:0] s, e, input logic [31:0] c);
    logic [1:0]  r;
    logic [31:0] d;
    int          n;
    axw(TYPE_ADDR, {24'h0, ty}, r);
    axw(HWPS_START_ADDR, {26'h0, s}, r);
    axw(HWPS_END_ADDR, {26'h0, e}, r);
    axw(HWPS_CTRL_ADDR, c, r);
    d = 32'h8000;
    for (n = 0; n < 20 && d[15]; n++)
      rd(HWPS_STATUS_ADDR, d, r);
  endtask
  task automatic moveTo(input logic signed [31:0] p);
    int n;
    @(posedge clk);
    target <= p;
    for (n = 0; n < 200 && measuredPos !== p; n++)
      @(negedge clk);
    repeat (2) @(negedge clk);
  endtask
  // ==========================================
  // Scenarios
  // ==========================================
  task automatic t_regs();
    logic [1:0]  r;
    logic [31:0] d;
    rd(HWPS_STATUS_ADDR, d, r);
    check(d, 32'h0);
    axw(8'h20, 32'h1, r);
    check(r, HWPS_RESP_SLVERR);
    rd(8'h06, d, r);
    check(r, HWPS_RESP_SLVERR);
    check(d, 32'h0);
  endtask
  task automatic t_inc();
    logic [1:0]  r;
    logic [31:0] d;
    fill(6'h0, 32'h64, 32'hC8, 32'h12C);
    cmd(8'h2B, 6'h0, 6'h2, 32'h31);
    rd(HWPS_STATUS_ADDR, d, r);
    check(d[6:0], 32'h3);
    check(switchOut, 32'h0);
    rd(HWPS_CTRL_ADDR, d, r);
    check(d, 32'h31);
    rd(HWPS_POS_ADDR, d, r);
    check(d, 32'h64);
    moveTo(32'h96);
    check(switchOut, 32'h1);
    rd(HWPS_POS_ADDR, d, r);
    check(d, 32'hC8);
    moveTo(32'hFA);
    check(switchOut, 32'h0);
    moveTo(32'h15E);
    check(switchOut, 32'h1);
    rd(HWPS_STATUS_ADDR, d, r);
    check(d[6:0], 32'h0);
  endtask
  task automatic t_dec();
    logic [1:0]  r;
    logic [31:0] d;
    axw(HWPS_CTRL_ADDR, 32'h2, r);
    fill(6'h4, 32'h12C, 32'hC8, 32'h64);
    cmd(8'h2C, 6'h4, 6'h6, 32'h01);
    check(switchOut, 32'h1);
    moveTo(32'hFA);
    check(switchOut, 32'h0);
    axw(HWPS_CTRL_ADDR, 32'h0, r);
    moveTo(32'h96);
    check(switchOut, 32'h0);
    rd(HWPS_STATUS_ADDR, d, r);
    check(d[6:0], 32'h2);
    axw(HWPS_CTRL_ADDR, 32'h2, r);
    rd(HWPS_STATUS_ADDR, d, r);
    check(d[6:0], 32'h0);
  endtask
  task automatic t_types();
    logic [1:0]  r;
    logic [31:0] d;
    moveTo(32'h0);
    cmd(8'h2E, 6'h0, 6'h2, 32'h31);
    rd(HWPS_STATUS_ADDR, d, r);
    check(d[14], 32'h1);
    check(d[6:0], 32'h0);
    cmd(8'h2D, 6'h0, 6'h2, 32'h31);
    rd(HWPS_STATUS_ADDR, d, r);
    check(d[6:0], 32'h3);
  endtask
  task automatic results();
    $display("Compared %0d, mismatches %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  initial
  begin
    repeat (16) @(posedge clk);
    reset <= 1'b0;
    t_regs();
    t_inc();
    t_dec();
    t_types();
    results();
  end
  // Runs need a few thousand cycles at most
  initial
  begin
    repeat (20000) @(posedge clk);
    failures++;
    results();
  end
endmodule
